// *** rtl/spc2_top.sv ***
// Purpose: Serial peripheral with second control register behaviour
// Assumes: Avalon-MM slave, one wait cycle per access, mode 0 shifting
// Notes:   Serial clock from partner is sampled, never used as a clock
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module spc2_top #(
	parameter int HALF = spc2_pkg::SCK_HALF_CY
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output      logic [31:0] AVS_READDATA,
	output      logic        AVS_WAITREQUEST,
	output      logic        IRQ,
	input  wire logic        WAIT_MODE,
	input  wire logic        SCK_IN,
	output      logic        SCK_OUT,
	output      logic        SCK_OE,
	input  wire logic        MOSI_IN,
	output      logic        MOSI_OUT,
	output      logic        MOSI_OE,
	input  wire logic        MISO_IN,
	output      logic        MISO_OUT,
	output      logic        MISO_OE,
	input  wire logic        SS_IN,
	output      logic        SS_OUT,
	output      logic        SS_OE
);
	typedef enum logic [1:0] {IDLE, SHIFT, DONE} spc2_st_t;

	typedef struct packed {
		spc2_st_t    fsm;
		logic [7:0]  ctrl1;
		logic [7:0]  ctrl2;
		logic [7:0]  stat;
		logic [7:0]  mask;
		logic [15:0] txbuf;
		logic [15:0] rxbuf;
		logic [15:0] match;
		logic [15:0] shreg;
		logic [4:0]  bits;
		logic        phase;
		logic        sck_d;
		logic        ack;
		logic        wreq;
		logic [31:0] rdata;
		logic        irq;
		logic        sck;
		logic        sck_oe;
		logic        mosi_o;
		logic        mosi_oe;
		logic        miso_o;
		logic        miso_oe;
		logic        ss_o;
		logic        ss_oe;
	} spc2_t;

	spc2_t st_ff;
	spc2_t nxt_st;

	logic [3:0] pins_s;
	logic       tick;
	logic       busy;
	logic       halted;

	// ****************************************
	// Pin synchronisers and divider
	// ****************************************
	spc2_sync #(.W(4)) u_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   ({SS_IN, SCK_IN, MISO_IN, MOSI_IN}),
		.q   (pins_s)
	);

	assign busy = (st_ff.fsm == SHIFT);
	// Gated when halted so no edges advance the shifter in wait
	assign halted = st_ff.ctrl2[spc2_pkg::B_HALT] & WAIT_MODE;

	spc2_div #(.HALF(HALF)) u_div (
		.clk  (CLK_SYS),
		.rst  (RST),
		.clr  (!busy),
		.run  (st_ff.ctrl1[spc2_pkg::B_MSTR] & !halted),
		.tick (tick)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic       mstr;
		logic       swire;
		logic       wide;
		logic       modf;
		logic       din;
		logic       s_edge_r;
		logic       s_edge_f;
		logic       sample;
		logic       shift;
		logic [4:0] nbits;
		logic [15:0] wd;
		logic [7:0] w8;
		logic [7:0] ev;
		din      = 1'b0;
		ev       = 8'h00;
		mstr     = st_ff.ctrl1[spc2_pkg::B_MSTR];
		swire    = st_ff.ctrl2[spc2_pkg::B_SWIRE];
		wide     = st_ff.ctrl2[spc2_pkg::B_WLEN];
		modf     = st_ff.ctrl2[spc2_pkg::B_MODF];
		nbits    = wide ? 5'h10 : 5'h08;
		wd       = AVS_WRITEDATA[15:0];
		w8       = AVS_WRITEDATA[7:0];
		s_edge_r = pins_s[2] & !st_ff.sck_d;
		s_edge_f = !pins_s[2] & st_ff.sck_d;
		// Single-wire: master listens on master-out pin, slave on master-in
		if (swire) begin
			din = mstr ? pins_s[0] : pins_s[1];
		end else begin
			din = mstr ? pins_s[1] : pins_s[0];
		end
		sample = 1'b0;
		shift  = 1'b0;
		nxt_st       = st_ff;
		nxt_st.sck_d = pins_s[2];
		nxt_st.ack   = 1'b0;

		// Serial engine
		if (st_ff.ctrl1[spc2_pkg::B_EN] && !halted) begin
			if (mstr) begin
				if (busy && tick) begin
					nxt_st.phase = !st_ff.phase;
					nxt_st.sck   = !st_ff.sck;
					sample = !st_ff.phase;
					shift  = st_ff.phase;
				end
			end else if (!pins_s[3]) begin
				if (st_ff.fsm == IDLE) begin
					nxt_st.fsm   = SHIFT;
					nxt_st.shreg = st_ff.txbuf;
					nxt_st.bits  = 5'h00;
				end
				sample = s_edge_r;
				shift  = s_edge_f;
			end else if (busy) begin
				nxt_st.fsm = IDLE;
			end
		end
		if (sample && busy) begin
			nxt_st.shreg = {st_ff.shreg[14:0], din};
			nxt_st.bits  = st_ff.bits + 5'h01;
			if (st_ff.bits + 5'h01 == nbits) begin
				nxt_st.fsm = DONE;
			end
		end
		if (st_ff.fsm == DONE) begin
			nxt_st.rxbuf = wide ? st_ff.shreg : {8'h00, st_ff.shreg[7:0]};
			ev[spc2_pkg::S_RXF] = 1'b1;
			ev[spc2_pkg::S_TXE] = 1'b1;
			if ((wide ? st_ff.shreg : {8'h00, st_ff.shreg[7:0]}) == st_ff.match) begin
				ev[spc2_pkg::S_MTCH] = 1'b1;
			end
			nxt_st.fsm   = IDLE;
			nxt_st.sck   = 1'b0;
			nxt_st.phase = 1'b0;
		end
		// Mode fault: master, fault enable set, select output off, pin low
		if (mstr && modf && !st_ff.ctrl1[spc2_pkg::B_SSOE] && !pins_s[3]) begin
			ev[spc2_pkg::S_MODF] = 1'b1;
			nxt_st.ctrl1[spc2_pkg::B_MSTR] = 1'b0;
			nxt_st.fsm = IDLE;
		end
		// Events of this cycle, kept apart so a status read cannot lose them
		nxt_st.stat = nxt_st.stat | ev;

		// Register bus, one wait cycle then answer
		if ((AVS_READ || AVS_WRITE) && !st_ff.ack) begin
			nxt_st.ack   = 1'b1;
			nxt_st.rdata = 32'h0000_0000;
			if (AVS_WRITE) begin
				unique case (AVS_ADDRESS)
					spc2_pkg::OFS_CTRL1: nxt_st.ctrl1 = w8 & spc2_pkg::CTRL1_WMASK;
					spc2_pkg::OFS_CTRL2: begin
						nxt_st.ctrl2 = w8 & spc2_pkg::CTRL2_WMASK;
						// Length change in master aborts and clears status
						if (mstr && (w8[spc2_pkg::B_WLEN] != wide)) begin
							nxt_st.fsm   = IDLE;
							nxt_st.stat  = spc2_pkg::STAT_RST;
							nxt_st.sck   = 1'b0;
							nxt_st.phase = 1'b0;
							nxt_st.bits  = 5'h00;
						end
					end
					spc2_pkg::OFS_DATA: begin
						nxt_st.txbuf = wide ? wd : {8'h00, w8};
						nxt_st.stat[spc2_pkg::S_TXE] = 1'b0;
						if (mstr && st_ff.fsm == IDLE) begin
							nxt_st.fsm   = SHIFT;
							nxt_st.shreg = wide ? wd : {w8, 8'h00};
							nxt_st.bits  = 5'h00;
						end
					end
					spc2_pkg::OFS_MATCH: nxt_st.match = wide ? wd : {8'h00, w8};
					spc2_pkg::OFS_MASK:  nxt_st.mask  = w8;
					default: ;
				endcase
			end else begin
				unique case (AVS_ADDRESS)
					spc2_pkg::OFS_CTRL1:  nxt_st.rdata = {24'h0, st_ff.ctrl1};
					spc2_pkg::OFS_CTRL2:  nxt_st.rdata = {24'h0, st_ff.ctrl2};
					spc2_pkg::OFS_STATUS: begin
						nxt_st.rdata = {24'h0, st_ff.stat};
						// Read clears, but events in the same cycle survive
						nxt_st.stat  = ev;
					end
					spc2_pkg::OFS_DATA:  nxt_st.rdata = {16'h0, st_ff.rxbuf};
					spc2_pkg::OFS_MATCH: nxt_st.rdata = {16'h0, st_ff.match};
					spc2_pkg::OFS_MASK:  nxt_st.rdata = {24'h0, st_ff.mask};
					default: ;
				endcase
			end
		end

		// Interrupt: match gated by bit 7, others by mask
		nxt_st.irq = (nxt_st.stat[spc2_pkg::S_MTCH] & nxt_st.ctrl2[spc2_pkg::B_MIE])
			| (|(nxt_st.stat & nxt_st.mask & 8'hFB));

		// Pin drivers
		nxt_st.mosi_o = shift || st_ff.fsm == IDLE ? nxt_st.shreg[15] : st_ff.mosi_o;
		nxt_st.miso_o = nxt_st.mosi_o;
		if (swire) begin
			// Output enable only matters in single-wire mode
			nxt_st.mosi_oe = mstr & nxt_st.ctrl2[spc2_pkg::B_BOE];
			nxt_st.miso_oe = !mstr & nxt_st.ctrl2[spc2_pkg::B_BOE] & !pins_s[3];
		end else begin
			nxt_st.mosi_oe = mstr;
			nxt_st.miso_oe = !mstr & !pins_s[3];
		end
		if (!st_ff.ctrl1[spc2_pkg::B_EN]) begin
			nxt_st.mosi_oe = 1'b0;
			nxt_st.miso_oe = 1'b0;
		end
		nxt_st.ss_oe = st_ff.ctrl1[spc2_pkg::B_EN] & mstr & modf
			& st_ff.ctrl1[spc2_pkg::B_SSOE];
		nxt_st.ss_o  = !(nxt_st.fsm != IDLE);
		nxt_st.wreq  = !nxt_st.ack;
		nxt_st.sck_oe = nxt_st.ctrl1[spc2_pkg::B_EN] & nxt_st.ctrl1[spc2_pkg::B_MSTR];
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_ff       <= '0;
			st_ff.fsm   <= IDLE;
			st_ff.ctrl2 <= spc2_pkg::CTRL2_RST;
			st_ff.ss_o  <= 1'b1;
			st_ff.wreq  <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign AVS_READDATA    = st_ff.rdata;
	assign AVS_WAITREQUEST = st_ff.wreq;
	assign IRQ             = st_ff.irq;
	assign SCK_OUT         = st_ff.sck;
	assign SCK_OE          = st_ff.sck_oe;
	assign MOSI_OUT        = st_ff.mosi_o;
	assign MOSI_OE         = st_ff.mosi_oe;
	assign MISO_OUT        = st_ff.miso_o;
	assign MISO_OE         = st_ff.miso_oe;
	assign SS_OUT          = st_ff.ss_o;
	assign SS_OE           = st_ff.ss_oe;

	// ****************************************
	// Checks
	// ****************************************
	a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_ff.ctrl2[5] == 1'b0) && (st_ff.ctrl2[2] == 1'b0))
		else $error("reserved control bits not zero");
	a_match_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_ff.stat[spc2_pkg::S_MTCH] && st_ff.ctrl2[spc2_pkg::B_MIE]) |-> IRQ)
		else $error("match interrupt missing");
	a_len_abort: assert property (@(posedge CLK_SYS) disable iff (RST)
		(AVS_WRITE && !st_ff.ack && AVS_ADDRESS == spc2_pkg::OFS_CTRL2
		&& st_ff.ctrl1[spc2_pkg::B_MSTR] && !(AVS_ADDRESS != spc2_pkg::OFS_CTRL2)
		&& AVS_WRITEDATA[6] != st_ff.ctrl2[6] && !pins_s[3] == 1'b0)
		|=> (st_ff.fsm == IDLE) && (st_ff.stat == 8'h00))
		else $error("length change did not abort");
	a_width_bits: assert property (@(posedge CLK_SYS) disable iff (RST)
		st_ff.bits <= (st_ff.ctrl2[6] ? 5'h10 : 5'h08))
		else $error("bit count exceeds length");
	a_oe_ignored: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!st_ff.ctrl2[0] && $stable(st_ff.ctrl2[0]) && st_ff.ctrl1[0] && st_ff.ctrl1[1])
		|=> MOSI_OE)
		else $error("driver off outside single-wire");
	a_swire_slave: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_ff.ctrl2[0] && !st_ff.ctrl1[1]) |=> !MOSI_OE)
		else $error("slave drove master-out in single-wire");
	a_ss_slave: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!st_ff.ctrl1[1] && !$past(st_ff.ctrl1[1])) |-> !SS_OE)
		else $error("slave drove select pin");
	a_halt_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
		(halted && busy) |=> $stable(st_ff.bits))
		else $error("shifter advanced while halted");
	a_bus_answer: assert property (@(posedge CLK_SYS) disable iff (RST)
		((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
		else $error("bus answer late");
endmodule

// *** rtl/spc2_pkg.sv ***
// Purpose: Shared constants for the serial peripheral with control register two
// Assumes: Avalon-MM word registers, 8-bit or 16-bit data in the low bits
// Notes:   All offsets and reset values are named here once
//
// Contract
// - Match irq enable bit 7 with match flag set raises an interrupt request.
// - Bit 6 selects 8-bit or 16-bit shift, match and buffer width.
// - Master mode length change aborts transfer, returns idle, clears all status bits.
// - In slave mode fault enable is ignored; select pin is slave select input.
// - Master: fault enable clear frees select pin; set makes it fault input or output.
// - Single-wire mode: bit 3 enables the data driver on the shared pin.
// - Single-wire uses master-out pin as master, master-in pin as slave.
// - Outside single-wire mode the single pin output enable is ignored.
// - Bit 1 set stops interface clocks while the processor waits.
// - Bit 0 selects separate pins or single-wire bidirectional operation.
package spc2_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] OFS_CTRL1  = 4'h0;
	localparam logic [3:0] OFS_CTRL2  = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_DATA   = 4'h3;
	localparam logic [3:0] OFS_MATCH  = 4'h4;
	localparam logic [3:0] OFS_MASK   = 4'h5;
	// ****************************************
	// Control two fields
	// ****************************************
	localparam int B_MIE   = 7;
	localparam int B_WLEN  = 6;
	localparam int B_MODF  = 4;
	localparam int B_BOE   = 3;
	localparam int B_HALT  = 1;
	localparam int B_SWIRE = 0;
	localparam logic [7:0] CTRL2_WMASK = 8'hDB;
	localparam logic [7:0] CTRL2_RST   = 8'h00;
	// ****************************************
	// Control one fields (enable, master, select output enable, clock polarity)
	// ****************************************
	localparam int B_EN    = 0;
	localparam int B_MSTR  = 1;
	localparam int B_SSOE  = 2;
	localparam int B_CPOL  = 3;
	localparam logic [7:0] CTRL1_WMASK = 8'h0F;
	localparam logic [7:0] CTRL1_RST   = 8'h00;
	// ****************************************
	// Status fields
	// ****************************************
	localparam int S_RXF  = 0;
	localparam int S_TXE  = 1;
	localparam int S_MTCH = 2;
	localparam int S_MODF = 3;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int  CLK_HZ      = 25000000;
	localparam int  SCK_HALF_NS = 160;
	localparam int  SCK_HALF_CY = (SCK_HALF_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [7:0] DIV_RST = 8'h00;
endpackage

// *** rtl/spc2_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to CLK_SYS
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module spc2_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} spc2_sy_t;
	spc2_sy_t st_ff;
	spc2_sy_t nxt_st;

	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule

// *** rtl/spc2_div.sv ***
// Purpose: Serial clock half-period enable divider
// Assumes: One clock; output is a one-cycle enable pulse
// Notes:   Counter restarts while held in clear
`timescale 1ns/1ps
module spc2_div #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clr,
	input  wire logic run,
	output      logic tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} spc2_dv_t;
	spc2_dv_t st_ff;
	spc2_dv_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.tick = 1'b0;
		if (clr) begin
			nxt_st.cnt = spc2_pkg::DIV_RST;
		end else if (run) begin
			if (st_ff.cnt == 8'(HALF - 1)) begin
				nxt_st.cnt  = spc2_pkg::DIV_RST;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule

// *** sim/spc2_peer.sv ***
// Purpose: Serial slave model facing the block in master mode
// Assumes: Clock idles low, shift on falling edge, sample on rising edge
// Notes:   Link clock is sampled by clk, never used as a clock
`timescale 1ns/1ps
module spc2_peer (
	input  wire logic        clk,
	input  wire logic        load,
	input  wire logic        wide,
	input  wire logic [15:0] word,
	input  wire logic        sck,
	input  wire logic        mosi,
	output      logic        miso,
	output      logic [15:0] got,
	output      logic [7:0]  bits
);
	logic [15:0] sh_ff;
	logic        sck_ff;
	assign miso = wide ? sh_ff[15] : sh_ff[7];
	always @(posedge clk) begin
		sck_ff <= sck;
		if (load) begin
			sh_ff <= word;
			got   <= 16'h0000;
			bits  <= 8'h00;
		end else if (sck && !sck_ff) begin
			got  <= {got[14:0], mosi};
			bits <= bits + 8'h01;
		end else if (!sck && sck_ff) begin
			// Refill with a toggling bit so stale data never looks valid
			sh_ff <= {sh_ff[14:0], ~sh_ff[0]};
		end
	end
endmodule

// *** sim/spi_control_two_config_tb.sv ***
// Purpose: Self-checking bench for the serial block and control register two
// Assumes: Block is master towards the peer model; bus waits on waitrequest
// Notes:   Pin levels resolved from output enables
`timescale 1ns/1ps
module spi_control_two_config_tb;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic [3:0]  adr    = 4'h0;
	logic        rd     = 1'b0;
	logic        wr     = 1'b0;
	logic [31:0] wdat   = 32'h0;
	logic        wmode  = 1'b0;
	logic        ss_drv = 1'b1;
	logic        p_load = 1'b0;
	logic        p_wide = 1'b0;
	logic [15:0] p_word = 16'h0000;
	logic        irq_seen = 1'b0;
	logic        irq_clr  = 1'b0;
	logic [31:0] rdat;
	logic        wreq, irq, sck_o, sck_e, mo_o, mo_e, mi_o, mi_e, ss_o, ss_e, p_miso;
	logic [15:0] p_got, st;
	logic [7:0]  p_bits, b;
	int          bad_count = 0;
	int          tests_run = 0;
	wire         sck_w = sck_e ? sck_o : 1'b0;
	wire         mo_w  = mo_e ? mo_o : 1'b1;
	wire         mi_w  = mi_e ? mi_o : p_miso;
	wire         ss_w  = ss_e ? ss_o : ss_drv;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (irq_clr) begin
			irq_seen <= 1'b0;
		end else if (irq === 1'b1) begin
			irq_seen <= 1'b1;
		end
	end
	spc2_top #(.HALF(4)) i_spc2_top (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .IRQ(irq), .WAIT_MODE(wmode), .SCK_IN(sck_w),
		.SCK_OUT(sck_o), .SCK_OE(sck_e), .MOSI_IN(mo_w), .MOSI_OUT(mo_o), .MOSI_OE(mo_e),
		.MISO_IN(mi_w), .MISO_OUT(mi_o), .MISO_OE(mi_e), .SS_IN(ss_w), .SS_OUT(ss_o),
		.SS_OE(ss_e));
	spc2_peer i_spc2_peer (.clk(clk), .load(p_load), .wide(p_wide), .word(p_word),
		.sck(sck_w), .mosi(mo_w), .miso(p_miso), .got(p_got), .bits(p_bits));
	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk);
		adr  <= a;
		wdat <= {16'h0000, d};
		wr   <= w;
		rd   <= ~w;
		// Request stands until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat[15:0];
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic seen_clr();
		irq_clr <= 1'b1;
		@(posedge clk);
		irq_clr <= 1'b0;
	endtask
	task automatic wr8(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		check(what, exp, q);
	endtask
	task automatic start(input logic [15:0] tx, input logic [15:0] ptx);
		@(posedge clk);
		p_word <= ptx;
		p_load <= 1'b1;
		@(posedge clk);
		p_load <= 1'b0;
		wr8(spc2_pkg::OFS_DATA, tx);
	endtask
	task automatic finish(input logic [15:0] tx, input logic [15:0] ptx);
		logic [15:0] q;
		int n;
		st = 16'h0000;
		n = 0;
		do begin
			bus(1'b0, spc2_pkg::OFS_STATUS, 16'h0000, q);
			st = st | q;
			n++;
		end while (q[0] !== 1'b1 && n < 200);
		check("rx full", 16'h0001, {15'h0, q[0]});
		rd_chk("rx data", spc2_pkg::OFS_DATA, ptx);
		check("peer rx", tx, p_got);
	endtask
	task automatic pin(input logic [15:0] c1, input logic [15:0] c2, input logic ss,
		input logic [2:0] exp);
		wr8(spc2_pkg::OFS_CTRL1, c1);
		wr8(spc2_pkg::OFS_CTRL2, c2);
		ss_drv <= ss;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("pin enables", {13'h0, exp}, {13'h0, mo_e, mi_e, ss_e});
	endtask
	task automatic complete_run();
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rd_chk("ctrl2 reset", spc2_pkg::OFS_CTRL2, 16'h0000);
		wr8(spc2_pkg::OFS_CTRL2, 16'h00FF);
		rd_chk("ctrl2 rw", spc2_pkg::OFS_CTRL2, 16'h00DB);
		rd_chk("unmapped", 4'hF, 16'h0000);
		wr8(spc2_pkg::OFS_CTRL2, 16'h0000);
	endtask
	task automatic t_irq();
		wr8(spc2_pkg::OFS_CTRL1, 16'h0003);
		wr8(spc2_pkg::OFS_MATCH, 16'h005A);
		wr8(spc2_pkg::OFS_CTRL2, 16'h0080);
		seen_clr();
		start(16'h00A5, 16'h005A);
		finish(16'h00A5, 16'h005A);
		check("irq by match", 16'h0001, {15'h0, irq_seen});
		check("irq cleared", 16'h0000, {15'h0, irq});
		wr8(spc2_pkg::OFS_CTRL2, 16'h0000);
		seen_clr();
		start(16'h00C3, 16'h005A);
		finish(16'h00C3, 16'h005A);
		check("match polled", 16'h0004, st & 16'h0004);
		check("irq gated", 16'h0000, {15'h0, irq_seen});
		wr8(spc2_pkg::OFS_MASK, 16'h0001);
		start(16'h0011, 16'h0022);
		finish(16'h0011, 16'h0022);
		check("irq by mask", 16'h0001, {15'h0, irq_seen});
		wr8(spc2_pkg::OFS_MASK, 16'h0000);
	endtask
	task automatic t_wide();
		int n;
		p_wide <= 1'b1;
		wr8(spc2_pkg::OFS_CTRL2, 16'h0040);
		wr8(spc2_pkg::OFS_MATCH, 16'h9ABC);
		start(16'h1234, 16'h9ABC);
		finish(16'h1234, 16'h9ABC);
		check("match 16", 16'h0004, st & 16'h0004);
		start(16'hFFFF, 16'h0F0F);
		n = 0;
		while (p_bits < 8'h03 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("peer started", 16'h0001, {15'h0, p_bits >= 8'h03});
		wr8(spc2_pkg::OFS_CTRL2, 16'h0000);
		p_wide <= 1'b0;
		rd_chk("status abort", spc2_pkg::OFS_STATUS, 16'h0000);
		b = p_bits;
		repeat (300) @(posedge clk);
		check("idle after abort", {8'h0, b}, {8'h0, p_bits});
		rd_chk("status idle", spc2_pkg::OFS_STATUS, 16'h0000);
		start(16'h003C, 16'h00C3);
		finish(16'h003C, 16'h00C3);
	endtask
	task automatic t_wait();
		wr8(spc2_pkg::OFS_CTRL2, 16'h0002);
		wmode <= 1'b1;
		start(16'h0066, 16'h0099);
		repeat (200) @(posedge clk);
		check("halted in wait", 16'h0000, {8'h0, p_bits});
		wmode <= 1'b0;
		finish(16'h0066, 16'h0099);
		wr8(spc2_pkg::OFS_CTRL2, 16'h0000);
		wmode <= 1'b1;
		start(16'h0081, 16'h0018);
		finish(16'h0081, 16'h0018);
		wmode <= 1'b0;
	endtask
	task automatic t_pins();
		pin(16'h0003, 16'h0000, 1'b1, 3'b100);
		pin(16'h0003, 16'h0008, 1'b1, 3'b100);
		pin(16'h0003, 16'h0009, 1'b1, 3'b100);
		pin(16'h0003, 16'h0001, 1'b1, 3'b000);
		pin(16'h0001, 16'h0009, 1'b0, 3'b010);
		// Deselect so the slave frame ends before turning master
		@(posedge clk);
		ss_drv <= 1'b1;
		repeat (4) @(posedge clk);
		pin(16'h0007, 16'h0010, 1'b1, 3'b101);
		check("select out idle", 16'h0001, {15'h0, ss_o});
		pin(16'h0007, 16'h0000, 1'b1, 3'b100);
		pin(16'h0005, 16'h0010, 1'b1, 3'b000);
		pin(16'h0003, 16'h0010, 1'b1, 3'b100);
		rd_chk("status clean", spc2_pkg::OFS_STATUS, 16'h0000);
		pin(16'h0003, 16'h0000, 1'b0, 3'b100);
		rd_chk("no fault", spc2_pkg::OFS_STATUS, 16'h0000);
		// Pin must be high before fault detection is enabled again
		ss_drv <= 1'b1;
		repeat (4) @(posedge clk);
		pin(16'h0003, 16'h0010, 1'b1, 3'b100);
		@(posedge clk);
		ss_drv <= 1'b0;
		repeat (6) @(posedge clk);
		rd_chk("mode fault", spc2_pkg::OFS_STATUS, 16'h0008);
		ss_drv <= 1'b1;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_wide();
		t_wait();
		t_pins();
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
